// *** clk_pwr_cfg.svh ***
`ifndef CLK_PWR_CFG_SVH
`define CLK_PWR_CFG_SVH

// register byte addresses
`define CPC_ADDR_PWR_KEY_A    32'hffff0404
`define CPC_ADDR_CORE_PWR     32'hffff0408
`define CPC_ADDR_PWR_KEY_B    32'hffff040c
`define CPC_ADDR_CLK_KEY_A    32'hffff0410
`define CPC_ADDR_CLK_CFG      32'hffff0414
`define CPC_ADDR_CLK_KEY_B    32'hffff0418
`define CPC_ADDR_PER_KEY_A    32'hffff0434
`define CPC_ADDR_PER_PWR      32'hffff0438
`define CPC_ADDR_PER_KEY_B    32'hffff043c
`define CPC_ADDR_STATUS       32'hffff0440

// key values
`define CPC_CLK_KEY_A_VAL     16'h00aa
`define CPC_CLK_KEY_B_VAL     16'h0055
`define CPC_PWR_KEY_A_VAL     16'h0001
`define CPC_PWR_KEY_B_VAL     16'h00f4
`define CPC_PER_KEY_A_VAL     16'h0076
`define CPC_PER_KEY_B_VAL     16'h00b1

// reset values and writable-bit masks
`define CPC_CLK_CFG_RST       16'h0021
`define CPC_CORE_PWR_RST      16'h0003
`define CPC_PER_PWR_RST       16'h0004
`define CPC_CLK_CFG_MASK      16'h0023
`define CPC_CORE_PWR_MASK     16'h0077
`define CPC_PER_PWR_MASK      16'h01ff

// field positions
`define CPC_REF_SEL_BIT       5
`define CPC_MODE_LSB          4
`define CPC_MODE_MSB          6
`define CPC_CORE_DIV_MSB      2
`define CPC_SPI_ON_BIT        8
`define CPC_SPI_DIV_LSB       6
`define CPC_I2C1_ON_BIT       5
`define CPC_I2C1_DIV_LSB      3
`define CPC_I2C0_ON_BIT       2
`define CPC_I2C0_DIV_LSB      0
`define CPC_ST_LOCK_BIT       0
`define CPC_ST_LOST_BIT       1
`define CPC_ST_IRQ_BIT        2

// field codes
`define CPC_CLKMODE_PLL       2'h1
`define CPC_CLKMODE_EXT       2'h3
`define CPC_MODE_ACTIVE       3'h0
`define CPC_MODE_PAUSE        3'h1
`define CPC_MODE_NAP          3'h2
`define CPC_MODE_SLEEP        3'h3
`define CPC_MODE_STOP         3'h4
`define CPC_PLL_MULT          11'h4fb

// timing
`define CPC_TICK_CNT_W        7
`define CPC_SYNC_STAGES       3

`endif

// *** clk_pwr_pkg.sv ***
package clk_pwr_pkg;

  // progress through one keyed write sequence
  typedef enum logic [1:0] {GUARD_IDLE, GUARD_ARMED, GUARD_LOADED} guard_t;

  // divider state
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } tick_state_t;

  // whole control state
  typedef struct packed {
    logic                 aw_v;
    logic [31:0]          aw_addr;
    logic                 w_v;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 b_v;
    logic [1:0]           b_resp;
    logic                 r_v;
    logic [31:0]          r_data;
    logic [1:0]           r_resp;
    logic [2:0][15:0]     regs;
    logic [2:0][15:0]     pend;
    guard_t [2:0]         guard;
    logic [2:0]           lock_sync;
    logic                 lock;
    logic                 lock_lost;
    logic [2:0][3:0]      irq_sync;
    logic [3:0]           irq;
  } ctl_state_t;

endpackage : clk_pwr_pkg

// *** keyed_clock_power_control.sv ***
// How it works
// - clock config needs aa, value, 55 sequence
// - reference select bit five: one internal
// - clocking mode 01 pll, 11 external pin
// - core power needs 01, value, f4 sequence
// - power key registers are write only
// - peripheral power needs 76, value, b1 sequence
// - mode bits six to four decode five modes
// - sleep or stop wakes on any interrupt
// - core clock is pll clock over 2**field
// - bit eight powers the spi block
// - spi divider by 1, 2, 4, 8
// - bits five and two power i2c channels
// - i2c dividers by 1, 4, 8, 32
// - pll multiplies reference by 1275
// - lock loss halts core, flags interrupt
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"

module keyed_clock_power_control
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // axi4-lite slave
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // pins from outside the clock domain
  input  wire logic        i_pll_lock,
  input  wire logic [3:0]  i_ext_irq,
  // control outputs
  output logic             o_reference_select,
  output logic [1:0]       o_clocking_mode_field,
  output logic             o_pll_mode_sel,
  output logic             o_ext_clock_sel,
  output logic [2:0]       o_operating_mode_field,
  output logic             o_pll_enable,
  output logic             o_xtal_enable,
  output logic             o_core_clk_en,
  output logic             o_spi_power_on,
  output logic             o_spi_clk_en,
  output logic             o_first_i2c_power_on,
  output logic             o_first_i2c_clk_en,
  output logic             o_second_i2c_power_on,
  output logic             o_second_i2c_clk_en,
  output logic             o_pll_irq
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per guarded register: key a, register, key b addresses and key values
  localparam logic [2:0][31:0] KA_ADDR = {`CPC_ADDR_PER_KEY_A, `CPC_ADDR_PWR_KEY_A,
                                          `CPC_ADDR_CLK_KEY_A};
  localparam logic [2:0][31:0] RG_ADDR = {`CPC_ADDR_PER_PWR, `CPC_ADDR_CORE_PWR,
                                          `CPC_ADDR_CLK_CFG};
  localparam logic [2:0][31:0] KB_ADDR = {`CPC_ADDR_PER_KEY_B, `CPC_ADDR_PWR_KEY_B,
                                          `CPC_ADDR_CLK_KEY_B};
  localparam logic [2:0][15:0] KA_VAL  = {`CPC_PER_KEY_A_VAL, `CPC_PWR_KEY_A_VAL,
                                          `CPC_CLK_KEY_A_VAL};
  localparam logic [2:0][15:0] KB_VAL  = {`CPC_PER_KEY_B_VAL, `CPC_PWR_KEY_B_VAL,
                                          `CPC_CLK_KEY_B_VAL};
  localparam logic [2:0][15:0] RG_MASK = {`CPC_PER_PWR_MASK, `CPC_CORE_PWR_MASK,
                                          `CPC_CLK_CFG_MASK};
  localparam logic [2:0][15:0] RG_RST  = {`CPC_PER_PWR_RST, `CPC_CORE_PWR_RST,
                                          `CPC_CLK_CFG_RST};

  clk_pwr_pkg::ctl_state_t st_q;
  clk_pwr_pkg::ctl_state_t st_d;

  logic        do_wr;
  logic        wr_hit;
  logic [31:0] wr_addr;
  logic [15:0] wr_val;
  logic [15:0] merged;
  logic [31:0] rd_addr;
  logic [2:0]  mode;
  logic        wake;
  logic        mode_core;
  logic        mode_periph;
  logic        core_tick;
  logic        spi_tick;
  logic        i2c0_tick;
  logic        i2c1_tick;
  logic [2:0]  spi_shift;
  logic [2:0]  i2c0_shift;
  logic [2:0]  i2c1_shift;

  // bus handshakes: one write and one read at a time
  assign o_awready = !st_q.aw_v && !st_q.b_v;
  assign o_wready  = !st_q.w_v && !st_q.b_v;
  assign o_arready = !st_q.r_v;
  assign o_bvalid  = st_q.b_v;
  assign o_bresp   = st_q.b_resp;
  assign o_rvalid  = st_q.r_v;
  assign o_rdata   = st_q.r_data;
  assign o_rresp   = st_q.r_resp;

  assign do_wr   = st_q.aw_v && st_q.w_v;
  assign wr_addr = {st_q.aw_addr[31:2], 2'h0};
  assign wr_val  = st_q.w_data[15:0];
  assign rd_addr = {i_araddr[31:2], 2'h0};

  // interrupt-driven wake from the sleep and stop modes
  assign mode = st_q.regs[1][`CPC_MODE_MSB:`CPC_MODE_LSB];
  assign wake = ((mode == `CPC_MODE_SLEEP) || (mode == `CPC_MODE_STOP))
                && (st_q.irq != 4'h0);

  // next state
  always_comb
  begin
    st_d   = st_q;
    wr_hit = 1'b0;
    merged = 16'h0000;

    // address and data channels, either order
    if (i_awvalid && o_awready)
    begin
      st_d.aw_v    = 1'b1;
      st_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready)
    begin
      st_d.w_v    = 1'b1;
      st_d.w_data = i_wdata;
      st_d.w_strb = i_wstrb;
    end
    if (st_q.b_v && i_bready)
      st_d.b_v = 1'b0;

    // three-stage synchronisers, change taken when last two agree
    st_d.lock_sync = {st_q.lock_sync[1:0], i_pll_lock};
    st_d.irq_sync  = {st_q.irq_sync[1:0], i_ext_irq};
    if (st_q.lock_sync[1] == st_q.lock_sync[2])
      st_d.lock = st_q.lock_sync[2];
    for (int b = 0; b < 4; b++)
    begin
      if (st_q.irq_sync[1][b] == st_q.irq_sync[2][b])
        st_d.irq[b] = st_q.irq_sync[2][b];
    end

    // keyed write sequences
    if (do_wr)
    begin
      st_d.aw_v   = 1'b0;
      st_d.w_v    = 1'b0;
      st_d.b_v    = 1'b1;
      st_d.b_resp = RESP_SLVERR;
      for (int k = 0; k < 3; k++)
      begin
        merged = st_q.regs[k];
        for (int y = 0; y < 2; y++)
        begin
          if (st_q.w_strb[y])
            merged[y*8 +: 8] = wr_val[y*8 +: 8];
        end
        if ((wr_addr == KA_ADDR[k]) || (wr_addr == RG_ADDR[k])
            || (wr_addr == KB_ADDR[k]))
          wr_hit = 1'b1;
        unique case (st_q.guard[k])
          clk_pwr_pkg::GUARD_IDLE:
          begin
            if ((wr_addr == KA_ADDR[k]) && (wr_val == KA_VAL[k]))
              st_d.guard[k] = clk_pwr_pkg::GUARD_ARMED;
          end
          clk_pwr_pkg::GUARD_ARMED:
          begin
            if (wr_addr == RG_ADDR[k])
            begin
              st_d.guard[k] = clk_pwr_pkg::GUARD_LOADED;
              st_d.pend[k]  = merged & RG_MASK[k];
            end
            else if ((wr_addr == KA_ADDR[k]) && (wr_val == KA_VAL[k]))
              st_d.guard[k] = clk_pwr_pkg::GUARD_ARMED;
            else
              st_d.guard[k] = clk_pwr_pkg::GUARD_IDLE;
          end
          clk_pwr_pkg::GUARD_LOADED:
          begin
            if ((wr_addr == KB_ADDR[k]) && (wr_val == KB_VAL[k]))
              st_d.regs[k] = st_q.pend[k];
            if ((wr_addr == KA_ADDR[k]) && (wr_val == KA_VAL[k]))
              st_d.guard[k] = clk_pwr_pkg::GUARD_ARMED;
            else
              st_d.guard[k] = clk_pwr_pkg::GUARD_IDLE;
          end
          default:
            st_d.guard[k] = clk_pwr_pkg::GUARD_IDLE;
        endcase
      end
      if (wr_addr == `CPC_ADDR_STATUS)
      begin
        wr_hit = 1'b1;
        if (st_q.w_strb[0] && st_q.w_data[`CPC_ST_LOST_BIT])
          st_d.lock_lost = 1'b0;
      end
      if (wr_hit)
        st_d.b_resp = RESP_OKAY;
    end

    // wake returns the mode field to active
    if (wake)
      st_d.regs[1][`CPC_MODE_MSB:`CPC_MODE_LSB] = `CPC_MODE_ACTIVE;

    // lock loss is sticky; a new loss beats a clear
    if (st_q.lock && !st_d.lock)
      st_d.lock_lost = 1'b1;

    // reads answer one cycle after the address is taken
    if (st_q.r_v && i_rready)
      st_d.r_v = 1'b0;
    if (i_arvalid && o_arready)
    begin
      st_d.r_v    = 1'b1;
      st_d.r_resp = RESP_OKAY;
      st_d.r_data = 32'h0000_0000;
      unique case (rd_addr)
        `CPC_ADDR_CLK_CFG:  st_d.r_data = {16'h0000, st_q.regs[0]};
        `CPC_ADDR_CORE_PWR: st_d.r_data = {16'h0000, st_q.regs[1]};
        `CPC_ADDR_PER_PWR:  st_d.r_data = {16'h0000, st_q.regs[2]};
        `CPC_ADDR_PWR_KEY_A, `CPC_ADDR_PWR_KEY_B, `CPC_ADDR_CLK_KEY_A,
        `CPC_ADDR_CLK_KEY_B, `CPC_ADDR_PER_KEY_A, `CPC_ADDR_PER_KEY_B:
          st_d.r_data = 32'h0000_0000;
        `CPC_ADDR_STATUS:
          st_d.r_data = {5'h00, `CPC_PLL_MULT, 13'h0000, o_pll_irq,
                         st_q.lock_lost, st_q.lock};
        default:
          st_d.r_resp = RESP_SLVERR;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      st_q       <= '0;
      st_q.regs  <= RG_RST;
      st_q.guard <= {3{clk_pwr_pkg::GUARD_IDLE}};
    end
    else
      st_q <= st_d;
  end

  // clock source selection
  assign o_reference_select    = st_q.regs[0][`CPC_REF_SEL_BIT];
  assign o_clocking_mode_field = st_q.regs[0][1:0];
  assign o_pll_mode_sel        = (st_q.regs[0][1:0] == `CPC_CLKMODE_PLL);
  assign o_ext_clock_sel       = (st_q.regs[0][1:0] == `CPC_CLKMODE_EXT);

  // operating mode decode; reserved codes behave as active
  assign o_operating_mode_field = mode;
  assign mode_core   = !((mode == `CPC_MODE_PAUSE) || (mode == `CPC_MODE_NAP)
                         || (mode == `CPC_MODE_SLEEP) || (mode == `CPC_MODE_STOP));
  assign mode_periph = mode_core || (mode == `CPC_MODE_PAUSE);
  assign o_pll_enable  = !((mode == `CPC_MODE_SLEEP) || (mode == `CPC_MODE_STOP));
  assign o_xtal_enable = (mode != `CPC_MODE_STOP);

  // peripheral power
  assign o_spi_power_on        = st_q.regs[2][`CPC_SPI_ON_BIT];
  assign o_second_i2c_power_on = st_q.regs[2][`CPC_I2C1_ON_BIT];
  assign o_first_i2c_power_on  = st_q.regs[2][`CPC_I2C0_ON_BIT];

  // divider ratios as powers of two
  assign spi_shift  = {1'b0, st_q.regs[2][`CPC_SPI_DIV_LSB +: 2]};
  always_comb
  begin
    unique case (st_q.regs[2][`CPC_I2C1_DIV_LSB +: 2])
      2'h0: i2c1_shift = 3'h0;
      2'h1: i2c1_shift = 3'h2;
      2'h2: i2c1_shift = 3'h3;
      2'h3: i2c1_shift = 3'h5;
    endcase
    unique case (st_q.regs[2][`CPC_I2C0_DIV_LSB +: 2])
      2'h0: i2c0_shift = 3'h0;
      2'h1: i2c0_shift = 3'h2;
      2'h2: i2c0_shift = 3'h3;
      2'h3: i2c0_shift = 3'h5;
    endcase
  end

  // core and peripheral clock enables
  pow2_tick_gen u_core_div
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_run     (mode_core && st_q.lock),
    .i_shift   (st_q.regs[1][`CPC_CORE_DIV_MSB:0]),
    .o_tick    (core_tick)
  );

  pow2_tick_gen u_spi_div
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_run     (mode_periph && o_spi_power_on),
    .i_shift   (spi_shift),
    .o_tick    (spi_tick)
  );

  pow2_tick_gen u_i2c0_div
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_run     (mode_periph && o_first_i2c_power_on),
    .i_shift   (i2c0_shift),
    .o_tick    (i2c0_tick)
  );

  pow2_tick_gen u_i2c1_div
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_run     (mode_periph && o_second_i2c_power_on),
    .i_shift   (i2c1_shift),
    .o_tick    (i2c1_tick)
  );

  // core halts the moment lock is seen lost
  assign o_core_clk_en       = core_tick && st_q.lock && mode_core;
  assign o_spi_clk_en        = spi_tick && mode_periph && o_spi_power_on;
  assign o_first_i2c_clk_en  = i2c0_tick && mode_periph && o_first_i2c_power_on;
  assign o_second_i2c_clk_en = i2c1_tick && mode_periph && o_second_i2c_power_on;

  // interrupt only offered once lock is back
  assign o_pll_irq = st_q.lock_lost && st_q.lock;

endmodule : keyed_clock_power_control

// *** keyed_clock_power_control_sva.sv ***
`timescale 1ns/1ps

// port-side checks of the keyed clock and power control block
module keyed_clock_power_control_sva
(
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       i_pll_lock,
  input wire logic [3:0] i_ext_irq,
  input wire logic       o_reference_select,
  input wire logic [1:0] o_clocking_mode_field,
  input wire logic       o_pll_mode_sel,
  input wire logic       o_ext_clock_sel,
  input wire logic [2:0] o_operating_mode_field,
  input wire logic       o_pll_enable,
  input wire logic       o_xtal_enable,
  input wire logic       o_core_clk_en,
  input wire logic       o_spi_power_on,
  input wire logic       o_spi_clk_en
);
  // one clock domain, so one default clock and disable
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  a_reset_vals: assert property (
    !$past(i_nrst) |-> o_reference_select && o_operating_mode_field == 3'h0)
    else $error("reference select or mode wrong after reset");
  a_mode_select: assert property (
    o_pll_mode_sel == (o_clocking_mode_field == 2'h1) &&
    o_ext_clock_sel == (o_clocking_mode_field == 2'h3))
    else $error("clock source select does not match field");
  a_pll_gate: assert property (
    o_pll_enable == !(o_operating_mode_field inside {3'h3, 3'h4}))
    else $error("pll enable wrong for mode");
  a_xtal_gate: assert property (
    o_xtal_enable == (o_operating_mode_field != 3'h4))
    else $error("crystal enable wrong for mode");
  a_pause_core: assert property (
    (o_operating_mode_field == 3'h1) [*3] |-> !o_core_clk_en)
    else $error("core clock runs while paused");
  a_wake_irq: assert property (
    o_operating_mode_field inside {3'h3, 3'h4} && i_ext_irq != 4'h0
    |-> ##[1:6] o_operating_mode_field == 3'h0)
    else $error("no wake on external interrupt");
  a_core_halt: assert property (
    !i_pll_lock [*6] |-> !o_core_clk_en)
    else $error("core clock runs without lock");
  a_spi_gate: assert property (
    !o_spi_power_on |-> !o_spi_clk_en)
    else $error("spi clock runs while powered down");
endmodule : keyed_clock_power_control_sva

bind keyed_clock_power_control keyed_clock_power_control_sva chk_u
(
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_pll_lock(i_pll_lock), .i_ext_irq(i_ext_irq),
  .o_reference_select(o_reference_select), .o_clocking_mode_field(o_clocking_mode_field),
  .o_pll_mode_sel(o_pll_mode_sel), .o_ext_clock_sel(o_ext_clock_sel),
  .o_operating_mode_field(o_operating_mode_field), .o_pll_enable(o_pll_enable),
  .o_xtal_enable(o_xtal_enable), .o_core_clk_en(o_core_clk_en),
  .o_spi_power_on(o_spi_power_on), .o_spi_clk_en(o_spi_clk_en)
);

// *** keyed_clock_power_control_test.sv ***
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"

module keyed_clock_power_control_test;
  logic        i_clk_sys = 1'b0, i_nrst = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic        i_arvalid = 1'b0, i_bready = 1'b1, i_rready = 1'b1, i_pll_lock = 1'b1;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata;
  logic [3:0]  i_wstrb = 4'hf, i_ext_irq = 4'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_reference_select;
  logic        o_pll_mode_sel, o_ext_clock_sel, o_pll_enable, o_xtal_enable, o_core_clk_en;
  logic        o_spi_power_on, o_spi_clk_en, o_first_i2c_power_on, o_first_i2c_clk_en;
  logic        o_second_i2c_power_on, o_second_i2c_clk_en, o_pll_irq;
  logic [2:0]  o_operating_mode_field;
  logic [1:0]  o_bresp, o_rresp, o_clocking_mode_field;
  logic [15:0] pv[3] = '{16'h01ff, 16'h012d, 16'h00a3};
  int          miscompares = 0, num_checks = 0, cycles = 0;
  int          n_c = 0, n_s = 0, n_f = 0, n_e = 0;

  keyed_clock_power_control dut_u
  (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .i_pll_lock(i_pll_lock),
    .i_ext_irq(i_ext_irq), .o_reference_select(o_reference_select),
    .o_clocking_mode_field(o_clocking_mode_field), .o_pll_mode_sel(o_pll_mode_sel),
    .o_ext_clock_sel(o_ext_clock_sel), .o_operating_mode_field(o_operating_mode_field),
    .o_pll_enable(o_pll_enable), .o_xtal_enable(o_xtal_enable),
    .o_core_clk_en(o_core_clk_en), .o_spi_power_on(o_spi_power_on),
    .o_spi_clk_en(o_spi_clk_en), .o_first_i2c_power_on(o_first_i2c_power_on),
    .o_first_i2c_clk_en(o_first_i2c_clk_en), .o_second_i2c_power_on(o_second_i2c_power_on),
    .o_second_i2c_clk_en(o_second_i2c_clk_en), .o_pll_irq(o_pll_irq)
  );

  // 25 mhz clock
  initial
  begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // pulse counters and hang guard
  always @(posedge i_clk_sys)
  begin
    cycles <= cycles + 1;
    n_c <= n_c + (o_core_clk_en === 1'b1);
    n_s <= n_s + (o_spi_clk_en === 1'b1);
    n_f <= n_f + (o_first_i2c_clk_en === 1'b1);
    n_e <= n_e + (o_second_i2c_clk_en === 1'b1);
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one axi write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
    i_awaddr  <= a;
    i_wdata   <= {16'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    forever
    begin
      @(posedge i_clk_sys);
      if (o_bvalid) break;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end
    chk("bresp", {30'h0, er}, {30'h0, o_bresp});
  endtask : wr

  // one axi read with expected data and response
  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    forever
    begin
      @(posedge i_clk_sys);
      if (o_rvalid) break;
      if (o_arready) i_arvalid <= 1'b0;
    end
    chk(what, exp, o_rdata);
    chk("rresp", {30'h0, er}, {30'h0, o_rresp});
  endtask : rd

  // keyed writes of the three guarded registers
  task automatic set_clk(input logic [15:0] v);
    wr(`CPC_ADDR_CLK_KEY_A, 16'h00aa, 2'h0);
    wr(`CPC_ADDR_CLK_CFG, v, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_B, 16'h0055, 2'h0);
  endtask : set_clk

  task automatic set_core(input logic [15:0] v);
    wr(`CPC_ADDR_PWR_KEY_A, 16'h0001, 2'h0);
    wr(`CPC_ADDR_CORE_PWR, v, 2'h0);
    wr(`CPC_ADDR_PWR_KEY_B, 16'h00f4, 2'h0);
  endtask : set_core

  task automatic set_per(input logic [15:0] v);
    wr(`CPC_ADDR_PER_KEY_A, 16'h0076, 2'h0);
    wr(`CPC_ADDR_PER_PWR, v, 2'h0);
    wr(`CPC_ADDR_PER_KEY_B, 16'h00b1, 2'h0);
  endtask : set_per

  // enable pulses seen over a 64-cycle window
  task automatic pulses(input int ec, input int es, input int ef, input int ee);
    int b[4];
    repeat (8) @(posedge i_clk_sys);
    b = '{n_c, n_s, n_f, n_e};
    repeat (64) @(posedge i_clk_sys);
    chk("core pulses", ec, n_c - b[0]);
    chk("spi pulses", es, n_s - b[1]);
    chk("i2c0 pulses", ef, n_f - b[2]);
    chk("i2c1 pulses", ee, n_e - b[3]);
  endtask : pulses

  // i2c divider codes map to shifts 0, 2, 3, 5
  function automatic int i2c_n(input logic on, input logic [1:0] f);
    if (!on) return 0;
    return 64 >> ((f == 2'h0) ? 0 : f + 1 + (f == 2'h3));
  endfunction : i2c_n

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    @(posedge i_clk_sys);
    rd("clk cfg", `CPC_ADDR_CLK_CFG, 32'h21, 2'h0);
    rd("core pwr", `CPC_ADDR_CORE_PWR, 32'h03, 2'h0);
    rd("per pwr", `CPC_ADDR_PER_PWR, 32'h04, 2'h0);
    rd("key a", `CPC_ADDR_PWR_KEY_A, 32'h0, 2'h0);
    rd("key b", `CPC_ADDR_PWR_KEY_B, 32'h0, 2'h0);
    rd("unmapped", 32'hffff0400, 32'h0, 2'h2);
    wr(32'hffff0400, 16'h0003, 2'h2);
    // unkeyed, wrong keys and an interloper all leave the value alone
    wr(`CPC_ADDR_CLK_CFG, 16'h0003, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_A, 16'h00aa, 2'h0);
    wr(`CPC_ADDR_CLK_CFG, 16'h0003, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_B, 16'h0056, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_A, 16'h00ab, 2'h0);
    wr(`CPC_ADDR_CLK_CFG, 16'h0003, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_B, 16'h0055, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_A, 16'h00aa, 2'h0);
    wr(`CPC_ADDR_PER_KEY_A, 16'h0000, 2'h0);
    wr(`CPC_ADDR_CLK_CFG, 16'h0003, 2'h0);
    wr(`CPC_ADDR_CLK_KEY_B, 16'h0055, 2'h0);
    rd("clk cfg", `CPC_ADDR_CLK_CFG, 32'h21, 2'h0);
    set_clk(16'h0003);
    rd("clk cfg", `CPC_ADDR_CLK_CFG, 32'h03, 2'h0);
    chk("ref sel", 32'h0, {31'h0, o_reference_select});
    chk("ext sel", 32'h1, {31'h0, o_ext_clock_sel});
    set_clk(16'h00ff);
    rd("clk cfg", `CPC_ADDR_CLK_CFG, 32'h23, 2'h0);
    set_clk(16'h0021);
    chk("pll sel", 32'h1, {31'h0, o_pll_mode_sel});
    // core divider sweep in active mode
    for (int cd = 0; cd < 7; cd++)
    begin
      set_core(16'(cd));
      pulses(64 >> cd, 0, 64, 0);
    end
    // peripheral power and dividers
    foreach (pv[i])
    begin
      set_per(pv[i]);
      rd("per pwr", `CPC_ADDR_PER_PWR, {16'h0, pv[i]}, 2'h0);
      chk("spi on", {31'h0, pv[i][8]}, {31'h0, o_spi_power_on});
      chk("i2c1 on", {31'h0, pv[i][5]}, {31'h0, o_second_i2c_power_on});
      chk("i2c0 on", {31'h0, pv[i][2]}, {31'h0, o_first_i2c_power_on});
      pulses(1, pv[i][8] ? 64 >> pv[i][7:6] : 0, i2c_n(pv[i][2], pv[i][1:0]),
             i2c_n(pv[i][5], pv[i][4:3]));
    end
    set_core(16'h0013);
    pulses(0, 0, 0, 64);
    set_core(16'h0023);
    chk("mode", 32'h2, {29'h0, o_operating_mode_field});
    pulses(0, 0, 0, 0);
    // sleep and stop, woken by each interrupt line
    for (int k = 0; k < 4; k++)
    begin
      set_core(k[0] ? 16'h0043 : 16'h0033);
      chk("mode", k[0] ? 32'h4 : 32'h3, {29'h0, o_operating_mode_field});
      i_ext_irq <= 4'h1 << k;
      repeat (8) @(posedge i_clk_sys);
      i_ext_irq <= 4'h0;
      rd("core pwr", `CPC_ADDR_CORE_PWR, 32'h03, 2'h0);
    end
    // lock loss halts the core and flags the pll interrupt
    i_pll_lock <= 1'b0;
    pulses(0, 0, 0, 64);
    i_pll_lock <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    chk("pll irq", 32'h1, {31'h0, o_pll_irq});
    rd("status", `CPC_ADDR_STATUS, 32'h04fb0007, 2'h0);
    wr(`CPC_ADDR_STATUS, 16'h0002, 2'h0);
    @(posedge i_clk_sys);
    chk("pll irq", 32'h0, {31'h0, o_pll_irq});
    report_and_stop();
  end
endmodule : keyed_clock_power_control_test

// *** pow2_tick_gen.sv ***
`timescale 1ns/1ps
`include "clk_pwr_cfg.svh"

// one tick every 2**i_shift cycles while i_run is high
module pow2_tick_gen
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_run,
  input  wire logic [2:0] i_shift,
  output logic            o_tick
);

  clk_pwr_pkg::tick_state_t st_q;
  clk_pwr_pkg::tick_state_t st_d;
  logic [6:0]               mask;

  // count up, tick when the low bits are all ones
  always_comb
  begin
    st_d = st_q;
    mask = 7'((8'h01 << i_shift) - 8'h01);
    if (!i_run)
    begin
      st_d.cnt  = 7'h00;
      st_d.tick = 1'b0;
    end
    else
    begin
      st_d.tick = ((st_q.cnt & mask) == mask);
      st_d.cnt  = st_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_tick = st_q.tick;

endmodule : pow2_tick_gen
